/* File: atacpe_defs.svh */
// constants for the ata command protocol engine
`ifndef ATACPE_DEFS_SVH
`define ATACPE_DEFS_SVH
`define ATACPE_SECTOR_BYTES   512
`define ATACPE_SECTOR_WORDS   (`ATACPE_SECTOR_BYTES / 2)
`define ATACPE_ECC_BYTES      4
`define ATACPE_FIFO_DEPTH     8
`define ATACPE_WORD_W         16
`define ATACPE_ERR_ABT_BIT    2
`define ATACPE_DEVHEAD_LBA    6
`define ATACPE_ERR_RST        8'h00
`endif

/* File: atacpe_pkg.sv */
// types for the ata command protocol engine
package atacpe_pkg;
  typedef enum logic [2:0] {
    CLS_NONDATA,
    CLS_PIO_IN,
    CLS_PIO_OUT,
    CLS_DMA_IN,
    CLS_DMA_OUT
  } atacpe_cls_e;

  typedef struct packed {
    atacpe_cls_e cls;
    logic        long_xfer;
    logic        multiple;
    logic [7:0]  dev_head;
    logic [15:0] count;
  } atacpe_cmd_s;

  typedef struct packed {
    logic busy;
    logic drdy;
    logic drq;
    logic err;
  } atacpe_stat_s;
endpackage : atacpe_pkg

/* File: atacpe_engine.sv */
// ata command handshake engine with its data fifo
`timescale 1ns/1ps
`include "atacpe_defs.svh"

module atacpe_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push, pop;
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || flush) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : atacpe_fifo

// Operation
// RULE1: host waits for busy clear and drive ready before any command.
// RULE2: from acceptance to completion busy or data request stays set.
// RULE3: interrupt raised on most busy one-to-zero transitions during commands.
// RULE4: only hardware or software reset terminates a running command.
// RULE5: host never writes command while busy or data request is set.
// RULE6: pending interrupt cleared by status read, reset or command write.
// RULE7: pio in: busy while preparing, then data request plus interrupt per unit.
// RULE8: host answers each interrupt with status read then one unit read.
// RULE9: long read presents a sector plus ecc bytes with the same handshake.
// RULE10: data transfers are 16 bits, ecc bytes of long commands 8 bits.
// RULE11: multiple commands move one block per interrupt, others one sector.
// RULE12: a sector's status is valid before its data moves.
// RULE13: invalid parameter: clear busy, set error and abort, interrupt.
// RULE14: data-in error: clear busy, set error and data request, log, interrupt.
// RULE15: failing location form chosen by device/head bit 6 latched at issue.
// RULE16: uncorrectable read data still goes to the buffer for the host.
// RULE17: pio out: data request per unit, busy while processing, then interrupt.
// RULE18: data-out uncorrectable error: clear busy, set error, log, interrupt.
// RULE19: non-data: busy on command, then clear busy and interrupt, no data request.
// RULE20: dma request asserted whenever any part of the data can move.
// RULE21: dma commands give one interrupt only after all data moved.
// RULE22: host prepares dma channel before command, resets it before status.
// RULE23: host loads parameter registers before writing the command code.
// RULE24: interrupt output is a level held until a clearing event.
module atacpe_engine
  import atacpe_pkg::*;
#(
  parameter int ECC_BYTES = `ATACPE_ECC_BYTES,
  parameter int DEPTH     = `ATACPE_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      srst,
  // host pins, asynchronous
  input  wire logic                      host_soft_rst,
  input  wire logic                      host_cmd_wr,
  input  wire atacpe_cmd_s               host_cmd,
  input  wire logic                      host_stat_rd,
  input  wire logic                      host_data_rd,
  input  wire logic                      host_data_wr,
  input  wire logic                      host_dma_ack,
  input  wire logic [`ATACPE_WORD_W-1:0] host_wdata,
  input  wire logic [7:0]                mult_sectors,
  // host facing status
  output atacpe_stat_s                   stat_ff,
  output logic [7:0]                     error_reg_ff,
  output logic [27:0]                    fail_addr_ff,
  output logic                           fail_lba_ff,
  output logic                           intrq_ff,
  output logic                           dmarq_ff,
  output logic [`ATACPE_WORD_W-1:0]      host_rdata_ff,
  output logic                           ecc_byte_ff,
  // media side, same clock
  input  wire logic                      be_done,
  input  wire logic                      be_abort,
  input  wire logic                      be_error,
  input  wire logic [7:0]                be_err_code,
  input  wire logic [27:0]               be_fail_addr,
  input  wire logic                      be_in_valid,
  output logic                           be_in_ready_ff,
  input  wire logic [`ATACPE_WORD_W-1:0] be_in_data,
  output logic                           be_out_valid_ff,
  input  wire logic                      be_out_ready,
  output logic [`ATACPE_WORD_W-1:0]      be_out_data_ff
);
  typedef enum logic [2:0] {ST_IDLE, ST_PREP, ST_XIN, ST_XOUT, ST_PROC, ST_DMA} atacpe_st_e;
  localparam int NS = 6;
  logic [NS-1:0]             s1_ff, s2_ff, s3_ff;
  logic [`ATACPE_WORD_W-1:0] wd1_ff, wd2_ff, f_in_data, f_out_data;
  atacpe_cmd_s               cd1_ff, cd2_ff, cmd_ff;
  atacpe_st_e                st_ff;
  logic [23:0]               words_left_ff, unit_words_ff, nxt_unit_words;
  logic [16:0]               secs_left_ff, blk, nxt_secs_left;
  logic                      last_unit_ff;
  logic                      soft_rst, cmd_wr, stat_rd, data_rd, data_wr, dma_ack;
  logic                      is_in, word_moved, irq_set, dma_last;
  logic                      f_in_valid, f_in_ready, f_out_valid, f_out_ready;

  // two-flop synchronisers, strobe edges taken between second and third stage, soft reset used as a level
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= {host_dma_ack, host_data_wr, host_data_rd, host_stat_rd,
                host_cmd_wr, host_soft_rst};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge mclk) begin
    wd1_ff <= host_wdata;
    wd2_ff <= wd1_ff;
    cd1_ff <= host_cmd;
    cd2_ff <= cd1_ff;
  end

  assign soft_rst = s2_ff[0];
  assign cmd_wr   = s2_ff[1] & ~s3_ff[1];
  assign stat_rd  = s2_ff[2] & ~s3_ff[2];
  assign data_rd  = s2_ff[3] & ~s3_ff[3];
  assign data_wr  = s2_ff[4] & ~s3_ff[4];
  assign dma_ack  = s2_ff[5] & ~s3_ff[5];

  // unit length: one block for multiple commands, else one sector [RULE11]
  assign blk = cmd_ff.multiple ? {9'h000, mult_sectors} : 17'h00001;
  assign nxt_secs_left = (secs_left_ff > blk) ? secs_left_ff - blk : 17'h00000;
  // long commands append ecc bytes to the sector [RULE9]
  assign nxt_unit_words = 24'(blk) * 24'(`ATACPE_SECTOR_WORDS)
                        + (cmd_ff.long_xfer ? 24'(ECC_BYTES) : 24'h000000);

  assign is_in = (cmd_ff.cls == CLS_PIO_IN) || (cmd_ff.cls == CLS_DMA_IN);
  assign dma_last = (words_left_ff == 24'h000000) || (word_moved && words_left_ff == 24'h000001);

  // fifo steering: media fills on reads, host fills on writes; only handshaken words move
  assign f_in_valid  = is_in ? (be_in_valid && be_in_ready_ff)
                             : (word_moved && st_ff != ST_IDLE);
  assign f_in_data   = is_in ? be_in_data : wd2_ff;
  assign f_out_ready = is_in ? word_moved : (be_out_ready && be_out_valid_ff);
  assign word_moved  = (st_ff == ST_XIN && data_rd) || (st_ff == ST_XOUT && data_wr)
                     || (st_ff == ST_DMA && dma_ack && dmarq_ff);

  atacpe_fifo #(.WIDTH(`ATACPE_WORD_W), .DEPTH(DEPTH)) u_fifo (
    .mclk      (mclk),
    .srst      (srst),
    .flush     (soft_rst || cmd_wr),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  always_ff @(posedge mclk) begin
    if (srst) begin
      be_in_ready_ff  <= 1'b0;
      be_out_valid_ff <= 1'b0;
      be_out_data_ff  <= '0;
      host_rdata_ff   <= '0;
      dmarq_ff        <= 1'b0;
    end else begin
      // ready is registered: skip a cycle after each accepted word so the fifo cannot overfill
      be_in_ready_ff  <= is_in && f_in_ready && st_ff != ST_IDLE
                         && !(be_in_ready_ff && be_in_valid);
      be_out_valid_ff <= !is_in && f_out_valid && !(be_out_valid_ff && be_out_ready);
      be_out_data_ff  <= f_out_data;
      host_rdata_ff   <= f_out_data;
      // request whenever a word can move in the present direction [RULE20]
      dmarq_ff <= st_ff == ST_DMA && words_left_ff != 24'h000000
                  && (is_in ? f_out_valid : f_in_ready) && !(dmarq_ff && dma_ack);
    end
  end

  // command sequencer; resets, and media abort or error, leave a command early [RULE4]
  always_ff @(posedge mclk) begin
    if (srst || soft_rst) begin
      st_ff         <= ST_IDLE;
      stat_ff       <= '{busy: 1'b0, drdy: 1'b1, drq: 1'b0, err: 1'b0};
      cmd_ff        <= '0;
      words_left_ff <= '0;
      unit_words_ff <= '0;
      secs_left_ff  <= '0;
      last_unit_ff  <= 1'b0;
      error_reg_ff  <= `ATACPE_ERR_RST;
      fail_addr_ff  <= '0;
      fail_lba_ff   <= 1'b0;
      ecc_byte_ff   <= 1'b0;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          if (cmd_wr) begin
            cmd_ff       <= cd2_ff;
            secs_left_ff <= {1'b0, cd2_ff.count};
            // location form latched at issue [RULE15]
            fail_lba_ff  <= cd2_ff.dev_head[`ATACPE_DEVHEAD_LBA];
            error_reg_ff <= `ATACPE_ERR_RST;
            stat_ff.err  <= 1'b0;
            stat_ff.busy <= 1'b1; // [RULE2] [RULE19]
            st_ff        <= (cd2_ff.cls == CLS_NONDATA) ? ST_PROC :
                            (cd2_ff.cls inside {CLS_DMA_IN, CLS_DMA_OUT}) ? ST_DMA : ST_PREP;
            words_left_ff <= 24'(cd2_ff.count) * 24'(`ATACPE_SECTOR_WORDS);
          end
        end
        ST_PREP: begin
          unit_words_ff <= nxt_unit_words;
          words_left_ff <= nxt_unit_words;
          ecc_byte_ff   <= 1'b0;
          if (be_abort) begin
            stat_ff.busy <= 1'b0; // [RULE13]
            stat_ff.err  <= 1'b1;
            error_reg_ff <= 8'h01 << `ATACPE_ERR_ABT_BIT;
            st_ff        <= ST_IDLE;
          end else if (be_done || be_error) begin
            // status for the unit is settled before data moves [RULE12]
            stat_ff.busy <= 1'b0; // [RULE7] [RULE17]
            stat_ff.drq  <= 1'b1;
            st_ff        <= is_in ? ST_XIN : ST_XOUT;
            secs_left_ff <= nxt_secs_left;
            last_unit_ff <= (nxt_secs_left == 17'h00000) || (be_error && is_in);
            if (be_error && is_in) begin
              // bad data is still offered from the buffer [RULE14] [RULE16]
              stat_ff.err  <= 1'b1;
              error_reg_ff <= be_err_code;
              fail_addr_ff <= be_fail_addr;
            end
          end
        end
        ST_XIN, ST_XOUT: begin
          if (word_moved) begin
            words_left_ff <= words_left_ff - 24'h000001;
            // ecc bytes move one per transfer [RULE10]
            ecc_byte_ff <= cmd_ff.long_xfer &&
                           (unit_words_ff - words_left_ff + 24'h000001 >= 24'(`ATACPE_SECTOR_WORDS));
            if (words_left_ff == 24'h000001) begin
              ecc_byte_ff <= 1'b0;
              stat_ff.drq <= 1'b0; // [RULE7]
              if (st_ff == ST_XOUT) begin
                stat_ff.busy <= 1'b1; // [RULE17]
                st_ff        <= ST_PROC;
              end else if (last_unit_ff) begin
                st_ff <= ST_IDLE;
              end else begin
                stat_ff.busy <= 1'b1; // [RULE2]
                st_ff        <= ST_PREP;
              end
            end
          end
        end
        ST_PROC: begin
          if (be_abort || be_error) begin
            stat_ff.busy <= 1'b0; // [RULE13] [RULE18]
            stat_ff.err  <= 1'b1;
            error_reg_ff <= be_abort ? (8'h01 << `ATACPE_ERR_ABT_BIT) : be_err_code;
            if (be_error && !be_abort) begin
              fail_addr_ff <= be_fail_addr;
            end
            st_ff <= ST_IDLE;
          end else if (be_done) begin
            stat_ff.busy <= 1'b0; // [RULE17] [RULE19]
            if (cmd_ff.cls == CLS_PIO_OUT && secs_left_ff != 17'h00000) begin
              stat_ff.drq   <= 1'b1; // [RULE2]
              unit_words_ff <= nxt_unit_words;
              words_left_ff <= nxt_unit_words;
              secs_left_ff  <= nxt_secs_left;
              st_ff         <= ST_XOUT;
            end else begin
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_DMA: begin
          if (word_moved) begin
            words_left_ff <= words_left_ff - 24'h000001;
          end
          if (be_abort || be_error) begin
            stat_ff.busy <= 1'b0;
            stat_ff.err  <= 1'b1;
            error_reg_ff <= be_abort ? (8'h01 << `ATACPE_ERR_ABT_BIT) : be_err_code;
            fail_addr_ff <= be_fail_addr;
            st_ff        <= ST_IDLE;
          end else if (dma_last) begin
            // media finishes the last write before the single interrupt [RULE21]
            st_ff <= (cmd_ff.cls == CLS_DMA_OUT) ? ST_PROC : ST_IDLE;
            stat_ff.busy <= (cmd_ff.cls == CLS_DMA_OUT);
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // interrupt on busy falling, not on the first data-out request nor between dma sectors [RULE3] [RULE21]
  assign irq_set = stat_ff.busy && st_ff != ST_IDLE &&
                   ((st_ff == ST_PREP && (be_abort || (is_in && (be_done || be_error)))) ||
                    (st_ff == ST_PROC && (be_abort || be_error || be_done)) ||
                    (st_ff == ST_DMA && (be_abort || be_error || (dma_last && is_in))));

  // held level, cleared by status read, reset or command write; reset wins over set, set wins over status read and command write [RULE6] [RULE24]
  always_ff @(posedge mclk) begin
    if (srst || soft_rst) begin
      intrq_ff <= 1'b0;
    end else if (irq_set) begin
      intrq_ff <= 1'b1;
    end else if (stat_rd || cmd_wr) begin
      intrq_ff <= 1'b0;
    end
  end
endmodule : atacpe_engine

/* File: atacpe_chk.sv */
// assertions on the command engine's host-facing behaviour
`timescale 1ns/1ps
`include "atacpe_defs.svh"
module atacpe_chk
  import atacpe_pkg::*;
(
  // clock and reset
  input wire logic         mclk,
  input wire logic         srst,
  // host pins
  input wire logic         host_soft_rst,
  input wire logic         host_cmd_wr,
  input wire atacpe_cmd_s  host_cmd,
  input wire logic         host_stat_rd,
  // media events
  input wire logic         be_done,
  input wire logic         be_abort,
  input wire logic         be_error,
  // status outputs
  input wire atacpe_stat_s stat_ff,
  input wire logic [7:0]   error_reg_ff,
  input wire logic         fail_lba_ff,
  input wire logic         intrq_ff,
  input wire logic         dmarq_ff
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  wire any_clr = host_stat_rd | host_cmd_wr | host_soft_rst;
  wire is_dma  = (host_cmd.cls == CLS_DMA_IN) || (host_cmd.cls == CLS_DMA_OUT);
  wire quiet   = !be_done && !be_abort && !be_error;

  property p_cmd_busy;
    $rose(host_cmd_wr) && !stat_ff.busy && !stat_ff.drq |-> ##[2:4] stat_ff.busy;
  endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("busy not raised");
  property p_abort;
    be_abort |-> ##[1:2] (!stat_ff.busy && stat_ff.err && error_reg_ff[`ATACPE_ERR_ABT_BIT] && intrq_ff);
  endproperty
  a_abort: assert property (p_abort) else $error("abort status wrong");
  property p_err_form;
    be_error |-> ##[1:2] (stat_ff.err && intrq_ff && fail_lba_ff == host_cmd.dev_head[6]);
  endproperty
  a_err_form: assert property (p_err_form) else $error("error report wrong");
  property p_irq_clr;
    $rose(host_stat_rd) && quiet ##1 quiet[*2] |-> ##[0:2] !intrq_ff;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared");
  property p_irq_hold;
    $fell(intrq_ff) |-> $past(any_clr, 2) || $past(any_clr, 3) || $past(any_clr, 4);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");
  property p_nodata;
    stat_ff.busy && host_cmd.cls == CLS_NONDATA |=> !stat_ff.drq;
  endproperty
  a_nodata: assert property (p_nodata) else $error("data request on non-data");
  property p_in_ready;
    $rose(stat_ff.drq) && host_cmd.cls == CLS_PIO_IN |-> !stat_ff.busy && intrq_ff;
  endproperty
  a_in_ready: assert property (p_in_ready) else $error("data-in handshake wrong");
  property p_out_proc;
    $fell(stat_ff.drq) && host_cmd.cls == CLS_PIO_OUT |-> stat_ff.busy;
  endproperty
  a_out_proc: assert property (p_out_proc) else $error("busy gap on data-out");
  property p_dma_quiet;
    dmarq_ff |-> !$rose(intrq_ff);
  endproperty
  a_dma_quiet: assert property (p_dma_quiet) else $error("interrupt mid dma");
  property p_dma_cls;
    $rose(dmarq_ff) |-> stat_ff.busy && is_dma;
  endproperty
  a_dma_cls: assert property (p_dma_cls) else $error("dma request outside dma");
endmodule : atacpe_chk

bind atacpe_engine atacpe_chk chk_u (.mclk(mclk), .srst(srst), .host_soft_rst(host_soft_rst),
  .host_cmd_wr(host_cmd_wr), .host_cmd(host_cmd), .host_stat_rd(host_stat_rd),
  .be_done(be_done), .be_abort(be_abort), .be_error(be_error), .stat_ff(stat_ff),
  .error_reg_ff(error_reg_ff), .fail_lba_ff(fail_lba_ff), .intrq_ff(intrq_ff),
  .dmarq_ff(dmarq_ff));

/* File: atacpe_host_mdl.sv */
// host controller model driving the task-file strobes
`timescale 1ns/1ps
module atacpe_host_mdl
  import atacpe_pkg::*;
(
  // clock
  input  wire logic         mclk,
  // device status
  input  wire atacpe_stat_s stat,
  input  wire logic         dmarq,
  input  wire logic         ecc,
  input  wire logic [15:0]  rdata,
  // strobes and data
  output logic              cmd_wr,
  output atacpe_cmd_s       cmd,
  output logic [3:0]        stb,
  output logic [15:0]       wdata
);
  logic [16:0] got[$];
  initial begin
    cmd_wr = 1'b0;
    cmd = '0;
    stb = 4'h0;
    wdata = 16'h0000;
  end
  // strobe high three cycles then low three, keeping strobes apart
  task automatic pulse(input int i);
    @(posedge mclk);
    stb[i] <= 1'b1;
    repeat (3) @(posedge mclk);
    stb[i] <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask : pulse
  task automatic issue(input atacpe_cmd_s c);
    int n = 0;
    while ((stat.busy !== 1'b0 || stat.drq !== 1'b0 || stat.drdy !== 1'b1) && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    cmd <= c;
    repeat (3) @(posedge mclk);
    cmd_wr <= 1'b1;
    repeat (3) @(posedge mclk);
    cmd_wr <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask : issue
  // one unit of words: strobe 1 pio read, 2 pio write, 3 dma
  task automatic move(input int i, input int n, input logic [15:0] base, input logic wr);
    int w;
    for (int k = 0; k < n; k++) begin
      w = 0;
      if (wr) begin
        @(posedge mclk);
        wdata <= base + 16'(k);
        repeat (3) @(posedge mclk);
      end
      while (i == 3 && dmarq !== 1'b1 && w < 300) begin
        @(posedge mclk);
        #1;
        w++;
      end
      if (!wr) got.push_back({ecc, rdata});
      pulse(i);
    end
  endtask : move
endmodule : atacpe_host_mdl

/* File: tb_top.sv */
// self-checking bench for the ata command protocol engine
`timescale 1ns/1ps
module tb_top
  import atacpe_pkg::*;
;
  logic         mclk = 1'b0;
  logic         srst = 1'b1;
  logic         soft_rst = 1'b0;
  logic         cmd_wr, lba, intrq, dmarq, ecc, in_ready, out_valid;
  logic         done = 1'b0, abort = 1'b0, berr = 1'b0, out_ready = 1'b0;
  atacpe_cmd_s  cmd;
  atacpe_stat_s stat;
  logic [3:0]   stb;
  logic [7:0]   ereg;
  logic [15:0]  wdata, rdata, out_data;
  logic [15:0]  in_data = 16'h0100;
  logic [27:0]  faddr_o;
  logic [27:0]  faddr_i = 28'h0123456;
  logic [7:0]   mult = 8'h02, ecode = 8'h40;
  int           feed_left = 0;
  int           num_errors = 0;
  int           num_checks = 0;
  logic [15:0]  drained[$];
  wire          in_valid = feed_left != 0;

  always #50 mclk = ~mclk;
  atacpe_engine dut_u (.mclk(mclk), .srst(srst), .host_soft_rst(soft_rst),
    .host_cmd_wr(cmd_wr), .host_cmd(cmd), .host_stat_rd(stb[0]), .host_data_rd(stb[1]),
    .host_data_wr(stb[2]), .host_dma_ack(stb[3]), .host_wdata(wdata), .mult_sectors(mult),
    .stat_ff(stat), .error_reg_ff(ereg), .fail_addr_ff(faddr_o), .fail_lba_ff(lba),
    .intrq_ff(intrq), .dmarq_ff(dmarq), .host_rdata_ff(rdata), .ecc_byte_ff(ecc),
    .be_done(done), .be_abort(abort), .be_error(berr), .be_err_code(ecode),
    .be_fail_addr(faddr_i), .be_in_valid(in_valid), .be_in_ready_ff(in_ready),
    .be_in_data(in_data), .be_out_valid_ff(out_valid), .be_out_ready(out_ready),
    .be_out_data_ff(out_data));
  atacpe_host_mdl host_u (.mclk(mclk), .stat(stat), .dmarq(dmarq), .ecc(ecc), .rdata(rdata),
    .cmd_wr(cmd_wr), .cmd(cmd), .stb(stb), .wdata(wdata));
  // media side: feeds a counted run of words, drains with a stall every other cycle
  always @(posedge mclk) begin
    if (in_valid && in_ready) begin
      in_data <= in_data + 16'h0001;
      feed_left <= feed_left - 1;
    end
    if (out_valid && out_ready) drained.push_back(out_data);
    out_ready <= ~out_ready;
  end

  task automatic chk_val(input logic [27:0] g, input logic [27:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_val
  // status as {busy, drq, err, intrq}
  task automatic chk_stat(input logic [3:0] e);
    chk_val(28'({stat.busy, stat.drq, stat.err, intrq}), 28'(e));
  endtask : chk_stat
  task automatic pulse_be(input int i);
    @(posedge mclk);
    {done, abort, berr} <= 3'(3'b100 >> i);
    @(posedge mclk);
    {done, abort, berr} <= 3'b000;
    repeat (3) @(posedge mclk);
    #1;
  endtask : pulse_be
  task automatic t_nondata;
    host_u.issue('{CLS_NONDATA, 1'b0, 1'b0, 8'h00, 16'h0001});
    chk_stat(4'b1000);
    pulse_be(0);
    chk_stat(4'b0001);
    host_u.pulse(0);
    chk_stat(4'b0000);
    $display("test nondata done");
  endtask : t_nondata
  task automatic t_pio_in(input logic lng, input logic mul, input int n);
    logic [15:0] base, w;
    mult <= mul ? 8'h02 : 8'h01;
    host_u.issue('{CLS_PIO_IN, lng, mul, 8'h00, 16'(mul ? 2 : 1)});
    base = in_data;
    @(posedge mclk);
    feed_left <= n;
    pulse_be(0);
    chk_stat(4'b0101);
    host_u.pulse(0);
    host_u.got.delete();
    host_u.move(1, n, 16'h0000, 1'b0);
    for (int k = 0; k < n; k++) begin
      w = base + 16'(k);
      if (k < 256 || !lng) chk_val(28'(host_u.got[k]), {12'h000, w});
      else chk_val(28'({host_u.got[k][16], host_u.got[k][7:0]}), {19'h0, 1'b1, w[7:0]});
    end
    chk_stat(4'b0000);
    $display("test pio in done");
  endtask : t_pio_in
  task automatic t_pio_out;
    host_u.issue('{CLS_PIO_OUT, 1'b0, 1'b0, 8'h00, 16'h0001});
    pulse_be(0);
    chk_stat(4'b0100);
    drained.delete();
    host_u.move(2, 256, 16'h5a00, 1'b1);
    chk_stat(4'b1000);
    repeat (20) @(posedge mclk);
    for (int k = 0; k < 256; k++) chk_val(28'(drained[k]), 28'(16'h5a00 + 16'(k)));
    pulse_be(0);
    chk_stat(4'b0001);
    host_u.pulse(0);
    $display("test pio out done");
  endtask : t_pio_out
  task automatic t_dma(input atacpe_cls_e c, input logic wr);
    logic [15:0] base;
    host_u.issue('{c, 1'b0, 1'b0, 8'h00, 16'h0001});
    base = wr ? 16'ha500 : in_data;
    @(posedge mclk);
    feed_left <= wr ? 0 : 256;
    drained.delete();
    host_u.got.delete();
    host_u.move(3, 256, base, wr);
    if (wr) begin
      repeat (20) @(posedge mclk);
      pulse_be(0);
    end
    chk_stat(4'b0001);
    for (int k = 0; k < 256; k++) begin
      chk_val(28'(wr ? drained[k] : host_u.got[k][15:0]), 28'(base + 16'(k)));
    end
    host_u.pulse(0);
    $display("test dma done");
  endtask : t_dma
  task automatic t_err;
    host_u.issue('{CLS_PIO_IN, 1'b0, 1'b0, 8'h00, 16'h0001});
    pulse_be(1);
    chk_stat(4'b0011);
    chk_val(28'(ereg), 28'h04);
    host_u.issue('{CLS_NONDATA, 1'b0, 1'b0, 8'h40, 16'h0001});
    chk_val(28'(intrq), 28'h0);
    pulse_be(2);
    chk_stat(4'b0011);
    chk_val(28'(ereg), 28'h40);
    chk_val(faddr_o, 28'h0123456);
    chk_val(28'(lba), 28'h1);
    host_u.pulse(0);
    $display("test errors done");
  endtask : t_err
  task automatic t_reset;
    logic [15:0] base;
    host_u.issue('{CLS_PIO_IN, 1'b0, 1'b0, 8'h00, 16'h0001});
    @(posedge mclk);
    ecode     <= 8'h10;
    faddr_i   <= 28'h0abcdef;
    feed_left <= 256;
    base = in_data;
    pulse_be(2);
    chk_stat(4'b0111);
    chk_val(28'(ereg), 28'h10);
    chk_val(faddr_o, 28'h0abcdef);
    chk_val(28'(lba), 28'h0);
    host_u.got.delete();
    host_u.move(1, 2, 16'h0000, 1'b0);
    chk_val(28'(host_u.got[0]), 28'(base));
    chk_val(28'(host_u.got[1]), 28'(base + 16'h0001));
    @(posedge mclk);
    soft_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    soft_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    feed_left <= 0;
    #1;
    chk_stat(4'b0000);
    $display("test reset done");
  endtask : t_reset
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_nondata();
    t_pio_in(1'b1, 1'b0, 260);
    t_pio_in(1'b0, 1'b1, 512);
    t_pio_out();
    t_dma(CLS_DMA_OUT, 1'b1);
    t_dma(CLS_DMA_IN, 1'b0);
    t_err();
    t_reset();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    close_out();
  end
endmodule : tb_top
